// [logic/irq_gate.sv]
// Gates raw peripheral flags with their enable bits, registered.
// Assumes flags arrive synchronous to ref_clk_in.
`timescale 1ns/1ns
module irq_gate import irq_enable_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire irq_flags_t flags_in,
    input wire logic [7:0] enable_a_in,
    input wire logic [7:0] enable_b_in,
    output irq_flags_t gated_out
);
    // Flags are only read here, never modified, so software sees them intact.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gated_out <= '0;
        end else begin
            gated_out.group_a <= flags_in.group_a & enable_a_in; // R1 R3 R4 R5 R9
            gated_out.group_b <= flags_in.group_b
                & enable_b_in[BIT_CAPTURE_TWO]; // R9
        end
    end
endmodule

// [logic/peripheral_irq_enable_regs.sv]
// Peripheral interrupt enable register bank with an Avalon-MM slave.
// Assumes peripheral flags arrive synchronous to ref_clk_in and that
// rst_n_in is driven by every reset source, power-up or otherwise.
// Operation
// R1: Enable bit 7 gates parallel port request.
// R2: Software keeps reserved bit 6 cleared.
// R3: Enable bit 5 gates receive request.
// R4: Enable bit 4 gates transmit request.
// R5: Enable bit 2 gates capture one request.
// R6: Second register holds capture two enable only.
// R7: Shared registers answer identically from either bank.
// R8: Pin and watchdog resets clear the registers.
// R9: Request needs flag and enable; flags untouched.
`timescale 1ns/1ns
module peripheral_irq_enable_regs import irq_enable_pkg::*; (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [7:0] flags_a_in,
    input wire logic flag_b_in,
    output logic [7:0] request_a_out,
    output logic request_b_out,
    output logic [7:0] enable_a_out,
    output logic enable_b_out,
    output logic irq_out
);
    avalon_req_t req;
    bus_state_t state_q;
    logic [7:0] enable_a_q;
    logic [7:0] enable_b_q;
    logic [7:0] status_q;
    logic [7:0] mask_q;
    logic [7:0] event_prev_q;
    logic [7:0] events;
    logic [7:0] rd_byte;
    logic take;
    logic done;
    logic wr_ok;
    logic status_read;
    irq_flags_t flags;
    irq_flags_t gated;

    assign req = '{address: avs_address_in, read: avs_read_in,
        write: avs_write_in, writedata: avs_writedata_in,
        byteenable: avs_byteenable_in};
    assign flags = '{group_a: flags_a_in, group_b: flag_b_in};

    // Shared registers ignore the bank bit, so either bank hits them.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
        hit = (a & BANK_STRIP) == (idx & BANK_STRIP); // R7
    endfunction

    // Each access is answered one cycle after it is presented.
    assign take = state_q == ST_IDLE && (req.read || req.write);
    // Writes commit only at the edge where the master sees waitrequest low.
    assign done = state_q == ST_DONE && (req.read || req.write);
    assign wr_ok = done && req.write && req.byteenable[0];
    assign status_read = take && req.read && hit(req.address, IDX_STATUS);

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // One reset input serves power-up, pin and watchdog alike.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            enable_a_q <= ENABLE_A_RESET; // R8
            enable_b_q <= ENABLE_B_RESET; // R8
        end else if (wr_ok) begin
            if (hit(req.address, IDX_ENABLE_A)) begin
                // Reserved bit is not stored, covering software slips.
                enable_a_q <= req.writedata[7:0] & ENABLE_A_WMASK; // R2
            end
            if (hit(req.address, IDX_ENABLE_B)) begin
                enable_b_q <= req.writedata[7:0] & ENABLE_B_WMASK; // R6
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_q <= MASK_RESET;
        end else if (wr_ok && hit(req.address, IDX_MASK)) begin
            mask_q <= req.writedata[7:0];
        end
    end

    irq_gate u_gate (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .flags_in(flags),
        .enable_a_in(enable_a_q),
        .enable_b_in(enable_b_q),
        .gated_out(gated)
    );

    // Rising edges of gated group a requests become sticky events; group b has none.
    assign events = gated.group_a & ~event_prev_q;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            event_prev_q <= STATUS_RESET;
        end else begin
            event_prev_q <= gated.group_a;
        end
    end

    // A new event in the clearing cycle survives the read.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_q <= STATUS_RESET;
        end else if (status_read) begin
            status_q <= events;
        end else begin
            status_q <= status_q | events;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (hit(req.address, IDX_ENABLE_A)) begin
            rd_byte = enable_a_q;
        end else if (hit(req.address, IDX_ENABLE_B)) begin
            rd_byte = enable_b_q & ENABLE_B_WMASK; // R6
        end else if (hit(req.address, IDX_STATUS)) begin
            rd_byte = status_q;
        end else if (hit(req.address, IDX_MASK)) begin
            rd_byte = mask_q;
        end else if (hit(req.address, IDX_RAW)) begin
            rd_byte = flags_a_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= UNMAPPED_DATA;
        end else if (take && req.read) begin
            avs_readdata_out <= {24'h00_0000, rd_byte};
        end
    end

    // Waitrequest stays high except in the answer cycle.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= !take;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            request_a_out <= 8'h00;
            request_b_out <= 1'b0;
            enable_a_out <= ENABLE_A_RESET;
            enable_b_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            request_a_out <= gated.group_a; // R9
            request_b_out <= gated.group_b; // R9
            enable_a_out <= enable_a_q;
            enable_b_out <= enable_b_q[BIT_CAPTURE_TWO];
            irq_out <= |((status_q | events) & mask_q);
        end
    end
endmodule

// [shared/irq_enable_pkg.sv]
// Shared constants and carriers for the peripheral interrupt enable bank.
// Assumes a byte-wide register space reached over a 32-bit Avalon-MM slave.
package irq_enable_pkg;
    localparam int ADDR_W = 8;
    // Printed offsets are not multiples of four: they are register indices.
    localparam logic [7:0] IDX_ENABLE_A = 8'h8c;
    localparam logic [7:0] IDX_ENABLE_B = 8'h8d;
    localparam logic [7:0] IDX_STATUS = 8'h40;
    localparam logic [7:0] IDX_MASK = 8'h41;
    localparam logic [7:0] IDX_RAW = 8'h42;
    // Bit 7 of an index is the bank select and is ignored for shared regs.
    localparam logic [7:0] BANK_STRIP = 8'h7f;
    localparam logic [7:0] ENABLE_A_RESET = 8'h00;
    localparam logic [7:0] ENABLE_B_RESET = 8'h00;
    localparam logic [7:0] ENABLE_A_WMASK = 8'hbf;
    localparam logic [7:0] ENABLE_B_WMASK = 8'h01;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    localparam int BIT_PARALLEL = 7;
    localparam int BIT_RESERVED = 6;
    localparam int BIT_RECEIVE = 5;
    localparam int BIT_TRANSMIT = 4;
    localparam int BIT_SYNC_SERIAL = 3;
    localparam int BIT_CAPTURE_ONE = 2;
    localparam int BIT_PERIOD_MATCH = 1;
    localparam int BIT_OVERFLOW = 0;
    localparam int BIT_CAPTURE_TWO = 0;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avalon_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avalon_rsp_t;

    // Peripheral flags: group a is the eight-bit bank, b holds capture two.
    typedef struct packed {
        logic [7:0] group_a;
        logic group_b;
    } irq_flags_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DONE = 2'b10
    } bus_state_t;
endpackage

// [verif/irq_enable_assertions.sv]
// Concurrent checks on the enable bank's bus slave and request gating.
// Assumes one clock domain and the port names of the bank's top module.
`timescale 1ns/1ns
module irq_enable_assertions import irq_enable_pkg::*; (
    input wire logic ref_clk_in, rst_n_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in, avs_write_in, avs_waitrequest_out,
    input wire logic [31:0] avs_writedata_in, avs_readdata_out,
    input wire logic [3:0] avs_byteenable_in,
    input wire logic [7:0] flags_a_in, request_a_out, enable_a_out,
    input wire logic flag_b_in, request_b_out, enable_b_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [8:0] f_q, g_q;
    logic wr_a, rd_b;
    // Expected request: flags two edges back, enable copy one edge back.
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            f_q <= 9'h000;
            g_q <= 9'h000;
        end else begin
            f_q <= {flags_a_in, flag_b_in};
            g_q <= f_q & {enable_a_out, enable_b_out};
        end
    end
    assign wr_a = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
        && (avs_address_in & BANK_STRIP) == (IDX_ENABLE_A & BANK_STRIP);
    assign rd_b = avs_read_in && !avs_waitrequest_out
        && (avs_address_in & BANK_STRIP) == (IDX_ENABLE_B & BANK_STRIP);
    property p_par; request_a_out[7] == g_q[8]; endproperty
    a_par: assert property (p_par) else $error("parallel gate off");
    property p_rx; request_a_out[5] == g_q[6]; endproperty
    a_rx: assert property (p_rx) else $error("receive gate off");
    property p_tx; request_a_out[4] == g_q[5]; endproperty
    a_tx: assert property (p_tx) else $error("transmit gate off");
    property p_cap1; request_a_out[2] == g_q[3]; endproperty
    a_cap1: assert property (p_cap1) else $error("capture one off");
    property p_cap2; request_b_out == g_q[0]; endproperty
    a_cap2: assert property (p_cap2) else $error("capture two off");
    property p_rsv; !enable_a_out[6]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit held");
    property p_wr_a;
        wr_a |-> ##2 enable_a_out ==
            ($past(avs_writedata_in[7:0], 2) & ENABLE_A_WMASK);
    endproperty
    a_wr_a: assert property (p_wr_a) else $error("enable write lost");
    property p_b_zero; rd_b |-> avs_readdata_out[31:1] == 31'h0; endproperty
    a_b_zero: assert property (p_b_zero) else $error("b upper bits");
    // One-cycle answer keeps the master's wait short and predictable.
    property p_take;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_take: assert property (p_take) else $error("late answer");
    property p_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
    a_one: assert property (p_one) else $error("answer too long");
    c_wr: cover property (wr_a);
    c_b: cover property (request_b_out);
    c_tx: cover property ($rose(request_a_out[4]));
endmodule

bind peripheral_irq_enable_regs irq_enable_assertions u_chk (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_byteenable_in(avs_byteenable_in), .flags_a_in(flags_a_in),
    .request_a_out(request_a_out), .enable_a_out(enable_a_out),
    .flag_b_in(flag_b_in), .request_b_out(request_b_out),
    .enable_b_out(enable_b_out));

// [verif/peripheral_irq_enable_regs_tb.sv]
// Self-checking bench for the enable bank: bus, gating, status and reset.
// Assumes the one-cycle Avalon-MM answer described for the slave.
`timescale 1ns/1ns
module peripheral_irq_enable_regs_tb import irq_enable_pkg::*;;
    logic ref_clk_in = 1'b0, rst_n_in = 1'b0;
    logic [7:0] avs_address_in = 8'h00, flags_a_in = 8'h00;
    logic avs_read_in = 1'b0, avs_write_in = 1'b0, flag_b_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
    logic [3:0] avs_byteenable_in = 4'h0;
    logic [3:0] lane_en = 4'hf;
    logic avs_waitrequest_out, request_b_out, enable_b_out, irq_out;
    logic [7:0] request_a_out, enable_a_out;
    int bad_count = 0, n_tests = 0;
    peripheral_irq_enable_regs dut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in), .irq_out(irq_out),
        .avs_readdata_out(avs_readdata_out), .flags_a_in(flags_a_in),
        .avs_waitrequest_out(avs_waitrequest_out), .flag_b_in(flag_b_in),
        .request_a_out(request_a_out), .request_b_out(request_b_out),
        .enable_a_out(enable_a_out), .enable_b_out(enable_b_out));
    always #20 ref_clk_in = ~ref_clk_in;
    task wrap_up;
        $display("mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // A hung slave ends the run here rather than stalling the bench.
    task bus(input logic w, input logic [7:0] a, d);
        int i;
        avs_address_in <= a;
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_writedata_in <= {24'h0, d};
        avs_byteenable_in <= lane_en;
        i = 0;
        do begin
            @(posedge ref_clk_in);
            i++;
        end while (avs_waitrequest_out !== 1'b0 && i < 40);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (avs_waitrequest_out !== 1'b0) begin
            bad_count++;
            wrap_up;
        end
        @(posedge ref_clk_in);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        check(nm, q, e);
    endtask
    task t_gate;
        bus(1'b1, IDX_ENABLE_A, 8'ha5);
        bus(1'b1, IDX_ENABLE_B, 8'hff);
        rd(IDX_ENABLE_B, 32'h1, "enb");
        check("enbo", {31'h0, enable_b_out}, 32'h1);
        flags_a_in <= 8'hff;
        flag_b_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        check("reqa", {24'h0, request_a_out}, 32'ha5);
        check("reqb", {31'h0, request_b_out}, 32'h1);
        rd(IDX_RAW, 32'hff, "raw");
        bus(1'b1, IDX_ENABLE_A, 8'h5a);
        bus(1'b1, IDX_ENABLE_B, 8'h00);
        repeat (2) @(posedge ref_clk_in);
        check("reqa2", {24'h0, request_a_out}, 32'h1a);
        check("reqb2", {31'h0, request_b_out}, 32'h0);
        rd(IDX_ENABLE_A, 32'h1a, "rsv");
        flags_a_in <= 8'h00;
        flag_b_in <= 1'b0;
    endtask
    task t_irq;
        // Edges left over from the gating scenario are still latched.
        rd(IDX_STATUS, 32'hbf, "stale");
        bus(1'b1, IDX_ENABLE_A & BANK_STRIP, 8'hff);
        rd(IDX_ENABLE_A, 32'hbf, "alias");
        lane_en = 4'he;
        bus(1'b1, IDX_ENABLE_A, 8'h00);
        lane_en = 4'hf;
        rd(IDX_ENABLE_A, 32'hbf, "lanes");
        rd(8'h55, 32'h0, "unmapped");
        bus(1'b1, IDX_MASK, 8'h20);
        flags_a_in <= 8'h30;
        repeat (5) @(posedge ref_clk_in);
        check("irq", {31'h0, irq_out}, 32'h1);
        rd(IDX_STATUS, 32'h30, "status");
        repeat (2) @(posedge ref_clk_in);
        check("irqclr", {31'h0, irq_out}, 32'h0);
        rd(IDX_RAW, 32'h30, "rawkept");
        bus(1'b1, IDX_MASK, 8'h00);
        flags_a_in <= 8'hb0;
        repeat (5) @(posedge ref_clk_in);
        check("irqmask", {31'h0, irq_out}, 32'h0);
        rd(IDX_STATUS, 32'h80, "status2");
        flags_a_in <= 8'h00;
    endtask
    task t_rst;
        bus(1'b1, IDX_ENABLE_B, 8'h01);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        check("enarst", {24'h0, enable_a_out}, 32'h0);
        check("enbrst", {31'h0, enable_b_out}, 32'h0);
        rd(IDX_ENABLE_A, 32'h0, "rdrst");
        rd(IDX_ENABLE_B, 32'h0, "rdrstb");
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        rd(IDX_ENABLE_A, 32'h0, "ena0");
        t_gate;
        t_irq;
        t_rst;
        wrap_up;
    end
endmodule
